// ### core/hic_regs.sv
// hub identity and first configuration byte register bank
// assumes reg_wr / reg_rd are one-cycle strobes from the serial slave engine,
// synchronous to ref_clk, with reg_addr and reg_wdata valid alongside
`timescale 1ns/1ps
`default_nettype none

module hic_regs
  import hic_pkg::*;
#(
  // arbitrary neutral defaults for the identity bytes
  parameter logic [7:0] VENDOR_ID_HIGH_RST = 8'h5a,
  parameter logic [7:0] PRODUCT_ID_LOW_RST = 8'ha5
) (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output var  logic [7:0] reg_rdata,
  output var  logic       reg_rvalid,
  output var  hic_ident_t ident
);

  // ==========================================================
  // address decode
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a >= HIC_FIRST_OFS) && (a < HIC_FIRST_OFS + 8'(HIC_NUM_REGS));
  endfunction

  function automatic logic [2:0] slot_of(input logic [7:0] a);
    logic [7:0] d;
    d = a - HIC_FIRST_OFS;
    slot_of = d[2:0];
  endfunction

  localparam logic [7:0] RST_VAL [HIC_NUM_REGS] = '{
    VENDOR_ID_HIGH_RST, PRODUCT_ID_LOW_RST, HIC_RST_PRODUCT_ID_HIGH,
    HIC_RST_RELEASE_NUMBER_LOW, HIC_RST_RELEASE_NUMBER_HIGH, HIC_RST_HUB_CONFIG_ONE};

  logic [7:0] regs_q [HIC_NUM_REGS];
  wire        wr_hit = reg_wr && is_mapped(reg_addr);
  wire        rd_hit = is_mapped(reg_addr);
  wire  [2:0] slot   = slot_of(reg_addr);
  wire  [7:0] rd_mux = rd_hit ? regs_q[slot] : HIC_RD_UNMAPPED;

  // ==========================================================
  // register storage, one byte per slot
  genvar gi;
  generate
    for (gi = 0; gi < HIC_NUM_REGS; gi++) begin : g_reg
      wire sel = wr_hit && (slot == 3'(gi));
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          regs_q[gi] <= RST_VAL[gi];
        end else if (sel) begin
          // whole byte stored; reserved bit 6 kept as written
          regs_q[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  // ==========================================================
  // read port, answer one cycle after the strobe
  logic [7:0] reg_rdata_q;
  logic       reg_rvalid_q;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reg_rdata_q  <= 8'h00;
      reg_rvalid_q <= 1'h0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rd_mux;
      end
    end
  end

  assign reg_rdata  = reg_rdata_q;
  assign reg_rvalid = reg_rvalid_q;

  // ==========================================================
  // values to the descriptor and power logic, straight from the bytes
  assign ident.vendor_upper_byte   = regs_q[HIC_IDX_VID_H];
  assign ident.product_id          = {regs_q[HIC_IDX_PID_H], regs_q[HIC_IDX_PID_L]};
  assign ident.release_number      = {regs_q[HIC_IDX_REL_H], regs_q[HIC_IDX_REL_L]};
  assign ident.power_scheme_select = regs_q[HIC_IDX_HUB_CONFIG_ONE][HIC_HUB_CONFIG_ONE_POWER_BIT];

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // identity seen right after any reset edge
  localparam hic_ident_t RST_IDENT = '{
    vendor_upper_byte:   VENDOR_ID_HIGH_RST,
    product_id:          {HIC_RST_PRODUCT_ID_HIGH, PRODUCT_ID_LOW_RST},
    release_number:      {HIC_RST_RELEASE_NUMBER_HIGH, HIC_RST_RELEASE_NUMBER_LOW},
    power_scheme_select: HIC_RST_HUB_CONFIG_ONE[HIC_HUB_CONFIG_ONE_POWER_BIT]
  };

  sequence wr_to(logic [7:0] ofs);
    reg_wr && reg_addr == ofs;
  endsequence

  // plain read, no write on the same edge
  sequence rd_of(logic [7:0] ofs);
    reg_rd && !reg_wr && reg_addr == ofs;
  endsequence

  // read and write of one offset on the same edge
  sequence rw_of(logic [7:0] ofs);
    reg_rd && reg_wr && reg_addr == ofs;
  endsequence

  // low then high release byte on consecutive edges
  sequence release_pair_s;
    wr_to(HIC_OFS_RELEASE_NUMBER_LOW) ##1 wr_to(HIC_OFS_RELEASE_NUMBER_HIGH);
  endsequence

  // high product byte written, then read on the next edge
  sequence write_then_read_s;
    wr_to(HIC_OFS_PRODUCT_ID_HIGH) ##1 rd_of(HIC_OFS_PRODUCT_ID_HIGH);
  endsequence

  sequence stray_write_s;
    reg_wr && !is_mapped(reg_addr);
  endsequence

  sequence stray_read_s;
    reg_rd && !is_mapped(reg_addr);
  endsequence

  vendor_write_a: assert property (wr_to(HIC_OFS_VENDOR_ID_HIGH) |=>
      ident.vendor_upper_byte == $past(reg_wdata))
    else $error("vendor upper byte not taken");

  vendor_alone_a: assert property (wr_to(HIC_OFS_VENDOR_ID_HIGH) |=>
      $stable(ident.product_id) && $stable(ident.release_number) && $stable(ident.power_scheme_select))
    else $error("vendor write disturbed another register");

  vendor_read_a: assert property (rd_of(HIC_OFS_VENDOR_ID_HIGH) |=>
      reg_rvalid && reg_rdata == $past(ident.vendor_upper_byte))
    else $error("vendor read differs from descriptor value");

  product_low_a: assert property (wr_to(HIC_OFS_PRODUCT_ID_LOW) |=>
      ident.product_id[7:0] == $past(reg_wdata) && $stable(ident.product_id[15:8]))
    else $error("product low byte not taken");

  product_high_a: assert property (wr_to(HIC_OFS_PRODUCT_ID_HIGH) |=>
      ident.product_id[15:8] == $past(reg_wdata) && $stable(ident.product_id[7:0]))
    else $error("product high byte not taken");

  product_read_a: assert property (rd_of(HIC_OFS_PRODUCT_ID_LOW) |=>
      reg_rvalid && reg_rdata == $past(ident.product_id[7:0]))
    else $error("product low read differs from descriptor value");

  release_low_a: assert property (wr_to(HIC_OFS_RELEASE_NUMBER_LOW) |=>
      ident.release_number[7:0] == $past(reg_wdata) && $stable(ident.release_number[15:8]))
    else $error("release low byte not taken");

  release_high_a: assert property (wr_to(HIC_OFS_RELEASE_NUMBER_HIGH) |=>
      ident.release_number[15:8] == $past(reg_wdata) && $stable(ident.release_number[7:0]))
    else $error("release high byte not taken");

  release_bytes_a: assert property (release_pair_s |=>
      ident.release_number == {$past(reg_wdata), $past(reg_wdata, 2)})
    else $error("release number bytes misplaced");

  release_read_a: assert property (rd_of(HIC_OFS_RELEASE_NUMBER_HIGH) |=>
      reg_rvalid && reg_rdata == $past(ident.release_number[15:8]))
    else $error("release high read differs from descriptor value");

  power_select_a: assert property (wr_to(HIC_OFS_HUB_CONFIG_ONE) |=>
      ident.power_scheme_select == $past(reg_wdata[HIC_HUB_CONFIG_ONE_POWER_BIT]))
    else $error("power scheme select not taken");

  power_alone_a: assert property (wr_to(HIC_OFS_HUB_CONFIG_ONE) |=>
      $stable(ident.vendor_upper_byte) && $stable(ident.product_id) && $stable(ident.release_number))
    else $error("config write disturbed an identity byte");

  power_read_a: assert property (rd_of(HIC_OFS_HUB_CONFIG_ONE) |=>
      reg_rvalid && reg_rdata[HIC_HUB_CONFIG_ONE_POWER_BIT] == $past(ident.power_scheme_select))
    else $error("config read differs from power scheme select");

  readback_value_a: assert property (write_then_read_s |=>
      reg_rvalid && reg_rdata == $past(reg_wdata, 2))
    else $error("read does not return last write");

  read_old_value_a: assert property (rw_of(HIC_OFS_VENDOR_ID_HIGH) |=>
      reg_rvalid && reg_rdata == $past(ident.vendor_upper_byte))
    else $error("read with write did not return old value");

  read_pulse_a: assert property (reg_rd |=>
      reg_rvalid)
    else $error("read strobe not answered");

  read_idle_a: assert property (!reg_rd |=>
      !reg_rvalid)
    else $error("read valid without a read");

  rdata_hold_a: assert property (!reg_rd |=>
      $stable(reg_rdata))
    else $error("read data changed without a read");

  hold_value_a: assert property (!reg_wr |=>
      $stable(ident))
    else $error("register changed without a write");

  unmapped_write_a: assert property (stray_write_s |=>
      $stable(ident))
    else $error("unmapped write changed a register");

  unmapped_read_a: assert property (stray_read_s |=>
      reg_rvalid && reg_rdata == HIC_RD_UNMAPPED)
    else $error("unmapped read not zero");

  reset_defaults_a: assert property (disable iff (1'h0) !resetn |=>
      ident == RST_IDENT && !reg_rvalid)
    else $error("defaults not restored by reset");

endmodule

`default_nettype wire

// ### pkg/hic_pkg.sv
// package of the hub identity and configuration register bank
// assumes one byte-wide register port fed by the serial slave engine
package hic_pkg;

  // ==========================================================
  // register offsets on the serial port
  localparam logic [7:0] HIC_OFS_VENDOR_ID_HIGH      = 8'h01;
  localparam logic [7:0] HIC_OFS_PRODUCT_ID_LOW      = 8'h02;
  localparam logic [7:0] HIC_OFS_PRODUCT_ID_HIGH     = 8'h03;
  localparam logic [7:0] HIC_OFS_RELEASE_NUMBER_LOW  = 8'h04;
  localparam logic [7:0] HIC_OFS_RELEASE_NUMBER_HIGH = 8'h05;
  localparam logic [7:0] HIC_OFS_HUB_CONFIG_ONE      = 8'h06;

  // ==========================================================
  // bank geometry, register slots in offset order
  localparam int         HIC_NUM_REGS  = 6;
  localparam logic [7:0] HIC_FIRST_OFS = HIC_OFS_VENDOR_ID_HIGH;
  localparam int         HIC_IDX_VID_H = 0;
  localparam int         HIC_IDX_PID_L = 1;
  localparam int         HIC_IDX_PID_H = 2;
  localparam int         HIC_IDX_REL_L = 3;
  localparam int         HIC_IDX_REL_H = 4;
  localparam int         HIC_IDX_HUB_CONFIG_ONE  = 5;

  // ==========================================================
  // field positions of the first configuration byte
  localparam int HIC_HUB_CONFIG_ONE_POWER_BIT    = 7;
  localparam int HIC_HUB_CONFIG_ONE_RESERVED_BIT = 6;

  // ==========================================================
  // reset values without an identity meaning, and the value read at unmapped offsets
  localparam logic [7:0] HIC_RST_PRODUCT_ID_HIGH     = 8'h00;
  localparam logic [7:0] HIC_RST_RELEASE_NUMBER_LOW  = 8'h00;
  localparam logic [7:0] HIC_RST_RELEASE_NUMBER_HIGH = 8'h00;
  localparam logic [7:0] HIC_RST_HUB_CONFIG_ONE      = 8'h00;
  localparam logic [7:0] HIC_RD_UNMAPPED             = 8'h00;

  // ==========================================================
  // values handed to the descriptor and power logic
  typedef struct packed {
    logic [7:0]  vendor_upper_byte;
    logic [15:0] product_id;
    logic [15:0] release_number;
    logic        power_scheme_select;
  } hic_ident_t;

endpackage

// ### sim/hic_host.sv
// serial configuration host model on the byte register port
// assumes rising-edge ref_clk; drives at the falling edge
`timescale 1ns/1ps
`default_nettype none
module hic_host
  import hic_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata
);
  initial begin
    reg_wr    = 1'h0;
    reg_rd    = 1'h0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // reserved bit 6 of the first config byte always goes out as 0
  function automatic logic [7:0] keep_rsv(input logic [7:0] a, input logic [7:0] d);
    keep_rsv = (a == HIC_OFS_HUB_CONFIG_ONE) ? (d & 8'hbf) : d;
  endfunction
  // released lines show the inverse, never a stale value
  task automatic idle();
    reg_wr    = 1'h0;
    reg_rd    = 1'h0;
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr  = a;
    reg_wdata = keep_rsv(a, d);
    reg_wr    = 1'h1;
    @(negedge ref_clk);
    idle();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd   = 1'h1;
    @(negedge ref_clk);
    d = reg_rdata;
    v = reg_rvalid;
    idle();
  endtask
  // two writes on consecutive edges, strobe held between them
  task automatic wr2(input logic [7:0] a0, input logic [7:0] d0, input logic [7:0] a1, input logic [7:0] d1);
    @(negedge ref_clk);
    reg_addr  = a0;
    reg_wdata = keep_rsv(a0, d0);
    reg_wr    = 1'h1;
    @(negedge ref_clk);
    reg_addr  = a1;
    reg_wdata = keep_rsv(a1, d1);
    @(negedge ref_clk);
    idle();
  endtask
  // a write, then a read of the same offset on the next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q, output logic v);
    @(negedge ref_clk);
    reg_addr  = a;
    reg_wdata = keep_rsv(a, d);
    reg_wr    = 1'h1;
    @(negedge ref_clk);
    reg_wr    = 1'h0;
    reg_rd    = 1'h1;
    @(negedge ref_clk);
    q = reg_rdata;
    v = reg_rvalid;
    idle();
  endtask
  // read and write of one offset on the same edge
  task automatic rw(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q, output logic v);
    @(negedge ref_clk);
    reg_addr  = a;
    reg_wdata = keep_rsv(a, d);
    reg_wr    = 1'h1;
    reg_rd    = 1'h1;
    @(negedge ref_clk);
    q = reg_rdata;
    v = reg_rvalid;
    idle();
  endtask
endmodule
`default_nettype wire

// ### sim/test_hic_regs.sv
// self-checking bench of the identity register bank
// assumes the host model sim/hic_host.sv
`timescale 1ns/1ps
`default_nettype none
module test_hic_regs
  import hic_pkg::*;
;
  localparam logic [7:0] VID_RST = 8'h5a; // arbitrary identity value
  localparam logic [7:0] PID_RST = 8'ha5; // arbitrary identity value
  logic       ref_clk;
  logic       resetn;
  logic       reg_wr;
  logic       reg_rd;
  logic       reg_rvalid;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  hic_ident_t ident;
  int         fail_count = 0;
  int         total_checks = 0;
  logic [7:0] rst_v [HIC_NUM_REGS] = '{VID_RST, PID_RST, HIC_RST_PRODUCT_ID_HIGH, HIC_RST_RELEASE_NUMBER_LOW,
                                       HIC_RST_RELEASE_NUMBER_HIGH, HIC_RST_HUB_CONFIG_ONE};
  logic [7:0] new_v [HIC_NUM_REGS] = '{8'h3c, 8'h21, 8'h43, 8'h12, 8'h34, 8'h80};
  hic_regs #(.VENDOR_ID_HIGH_RST(VID_RST), .PRODUCT_ID_LOW_RST(PID_RST)) u_dut (.ref_clk(ref_clk),
    .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ident(ident));
  hic_host u_host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    u_host.rd(a, d, v);
    chk("reg_rvalid", 16'h0001, {15'h0, v});
    chk("reg_rdata", {8'h00, exp}, {8'h00, d});
  endtask
  task automatic check_defaults();
    for (int i = 0; i < HIC_NUM_REGS; i++) rdchk(HIC_FIRST_OFS + 8'(i), rst_v[i]);
    chk("power_scheme_select", {15'h0, HIC_RST_HUB_CONFIG_ONE[HIC_HUB_CONFIG_ONE_POWER_BIT]},
        {15'h0, ident.power_scheme_select});
  endtask
  task automatic check_writes();
    for (int i = 0; i < HIC_NUM_REGS; i++) u_host.wr(HIC_FIRST_OFS + 8'(i), new_v[i]);
    chk("vendor_upper_byte", 16'h003c, {8'h00, ident.vendor_upper_byte});
    chk("product_id", 16'h4321, ident.product_id);
    chk("release_number", 16'h3412, ident.release_number);
    chk("power_scheme_select", 16'h0001, {15'h0, ident.power_scheme_select});
    for (int i = 0; i < HIC_NUM_REGS; i++) rdchk(HIC_FIRST_OFS + 8'(i), new_v[i]);
  endtask
  task automatic check_bus_power_unmapped();
    u_host.wr(HIC_OFS_HUB_CONFIG_ONE, 8'h00);
    chk("power_scheme_select", 16'h0000, {15'h0, ident.power_scheme_select});
    u_host.wr(8'h07, 8'hff);
    rdchk(8'h07, HIC_RD_UNMAPPED);
    rdchk(HIC_OFS_VENDOR_ID_HIGH, 8'h3c);
  endtask
  task automatic check_back_to_back();
    logic [7:0] q;
    logic       v;
    u_host.wr2(HIC_OFS_RELEASE_NUMBER_LOW, 8'h78, HIC_OFS_RELEASE_NUMBER_HIGH, 8'h56);
    chk("release_number", 16'h5678, ident.release_number);
    u_host.wr_rd(HIC_OFS_PRODUCT_ID_HIGH, 8'h65, q, v);
    chk("reg_rvalid", 16'h0001, {15'h0, v});
    chk("reg_rdata", 16'h0065, {8'h00, q});
    chk("product_id", 16'h6521, ident.product_id);
    u_host.rw(HIC_OFS_VENDOR_ID_HIGH, 8'h99, q, v);
    chk("reg_rvalid", 16'h0001, {15'h0, v});
    chk("reg_rdata", 16'h003c, {8'h00, q});
    chk("vendor_upper_byte", 16'h0099, {8'h00, ident.vendor_upper_byte});
    @(negedge ref_clk);
    chk("reg_rvalid", 16'h0000, {15'h0, reg_rvalid});
    chk("reg_rdata", 16'h003c, {8'h00, reg_rdata});
  endtask
  task automatic check_reset_again();
    @(negedge ref_clk);
    resetn = 1'h0;
    repeat (2) @(negedge ref_clk);
    resetn = 1'h1;
    check_defaults();
  endtask
  task automatic stop_test();
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    resetn = 1'h0;
    repeat (20) @(negedge ref_clk);
    resetn = 1'h1;
    check_defaults();
    check_writes();
    check_bus_power_unmapped();
    check_back_to_back();
    check_reset_again();
    stop_test();
  end
endmodule
`default_nettype wire
